//--- include/fbsm_pkg.sv
package fbsm_pkg;
	// ==========================================
	// Device geometry and signature
	localparam int NUM_SECTORS = 16384;
	localparam int SPARE_SECTORS = 290;
	localparam int ECC_BITS = 3;
	localparam logic [11:0] SECTOR_BYTES = 12'h840;
	localparam logic [11:0] LAST_COL = 12'h83F;
	localparam logic [11:0] SIG_COL = 12'h820;
	localparam logic [2:0] SIG_LAST = 3'h5;
	localparam logic [47:0] SIG_PATTERN = 48'h1C71C71C71C7;
	// ==========================================
	// Device operation codes on dev_op
	localparam logic [2:0] OP_READ_BYTE = 3'h0;
	localparam logic [2:0] OP_LOAD_BYTE = 3'h1;
	localparam logic [2:0] OP_PROGRAM = 3'h2;
	localparam logic [2:0] OP_ERASE = 3'h3;
	localparam logic [2:0] OP_STATUS = 3'h4;
	localparam logic [2:0] OP_CLEAR = 3'h5;
	// ==========================================
	// Status byte flags
	localparam int FLAG_READY = 7;
	localparam int FLAG_ECC_HINT = 6;
	localparam int FLAG_ERASE_FAIL = 5;
	localparam int FLAG_PROG_FAIL = 4;
	// ==========================================
	// Register map and fields
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SECTOR = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_PHYS = 8'h0C;
	localparam logic [7:0] REG_SPARES = 8'h10;
	localparam logic [7:0] REG_CAPS = 8'h14;
	localparam logic [2:0] CMD_SCAN = 3'h1;
	localparam logic [2:0] CMD_PROGRAM = 3'h2;
	localparam logic [2:0] CMD_ERASE = 3'h3;
	localparam logic [2:0] CMD_READ = 3'h4;
endpackage

//--- verilog/fbsm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module fbsm_ctrl import fbsm_pkg::*; #(
	parameter int NS = NUM_SECTORS,
	parameter int SPARE_N = SPARE_SECTORS
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device side, four-phase request and acknowledge
	output logic dev_req,
	output logic [2:0] dev_op,
	output logic [$clog2(NS)-1:0] dev_sector,
	output logic [11:0] dev_col,
	output logic [7:0] dev_wdata,
	input wire logic dev_ack,
	input wire logic [7:0] dev_rdata,
	// External program data buffer
	output logic [11:0] buf_addr,
	input wire logic [7:0] buf_data,
	output logic buf_hold,
	// ECC engine
	output logic ecc_start,
	output logic ecc_valid,
	output logic [7:0] ecc_byte,
	input wire logic ecc_done,
	input wire logic ecc_fixable
);
	localparam int SW = $clog2(NS);
	localparam int RW = $clog2(SPARE_N);
	localparam int CW = $clog2(SPARE_N + 1);
	localparam logic [SW-1:0] POOL_LO = SW'(NS - SPARE_N);
	localparam logic [SW-1:0] POOL_HI = SW'(NS - 1);
	localparam logic [SW-1:0] HALF = SW'(NS / 2);
	localparam logic [CW-1:0] POOL_SIZE = CW'(SPARE_N);

	typedef enum logic [17:0] {
		ST_IDLE = 18'h00001,
		ST_SCAN_RD = 18'h00002,
		ST_SCAN_CHK = 18'h00004,
		ST_LOAD = 18'h00008,
		ST_LOAD_NEXT = 18'h00010,
		ST_PROG = 18'h00020,
		ST_ERASE = 18'h00040,
		ST_POLL = 18'h00080,
		ST_CHECK = 18'h00100,
		ST_CLEAR = 18'h00200,
		ST_DECIDE = 18'h00400,
		ST_ECC_RD = 18'h00800,
		ST_ECC_FEED = 18'h01000,
		ST_ECC_WAIT = 18'h02000,
		ST_REPLACE = 18'h04000,
		ST_REQ = 18'h08000,
		ST_REL = 18'h10000,
		ST_DONE = 18'h20000
	} fbsm_state_t;

	fbsm_state_t state, ret_state;
	logic ack_m, ack_s;
	logic [7:0] rd_m, rd_s, rd_byte;
	logic [11:0] cnt;
	logic [SW-1:0] scan_sec, lsect, phys, lo_ptr, hi_ptr;
	logic [NS-1:0] bad;
	logic [SW-1:0] remap_log [SPARE_N];
	logic [SW-1:0] remap_phy [SPARE_N];
	logic [SPARE_N-1:0] remap_v;
	logic [RW-1:0] next_slot;
	logic [CW-1:0] spares_left;
	logic [2:0] op_kind;
	logic [7:0] last_stat;
	logic busy, scanned, err, replaced, uncorr;

	// ==========================================
	// Register decode
	wire apb_write = psel & penable & pready & pwrite;
	wire sel_ctrl = (paddr == REG_CTRL);
	wire sel_sector = (paddr == REG_SECTOR);
	wire sel_status = (paddr == REG_STATUS);
	wire sel_phys = (paddr == REG_PHYS);
	wire sel_spares = (paddr == REG_SPARES);
	wire sel_caps = (paddr == REG_CAPS);
	wire mapped_addr = sel_ctrl | sel_sector | sel_status | sel_phys | sel_spares | sel_caps;
	wire [31:0] status_word = {16'h0000, last_stat, 3'h0, uncorr, replaced, err, scanned, busy};
	wire [31:0] read_word = sel_ctrl ? {29'h0, op_kind} :
		sel_sector ? {{(32-SW){1'b0}}, lsect} :
		sel_status ? status_word :
		sel_phys ? {{(32-SW){1'b0}}, phys} :
		sel_spares ? {{(32-CW){1'b0}}, spares_left} :
		sel_caps ? 32'(ECC_BITS) : 32'h0000_0000;
	wire start = apb_write & sel_ctrl & ~busy;
	wire [2:0] cmd = pwdata[2:0];

	// ==========================================
	// Logical to physical lookup
	logic hit;
	logic [RW-1:0] hit_idx;
	always_comb begin
		hit = 1'b0;
		hit_idx = '0;
		for (int i = 0; i < SPARE_N; i++) begin
			if (remap_v[i] && remap_log[i] == lsect) begin
				hit = 1'b1;
				hit_idx = RW'(i);
			end
		end
	end
	wire [SW-1:0] mapped = hit ? remap_phy[hit_idx] : lsect;
	wire cmd_ok = scanned & (lsect < POOL_LO) & ~bad[mapped];

	// High end of the pool for a failed sector below HALF, low end of the pool otherwise.
	wire want_hi = (phys < HALF);
	wire [SW-1:0] cand = want_hi ? hi_ptr : lo_ptr;
	wire [2:0] sig_idx = cnt[2:0];
	wire [7:0] sig_byte = SIG_PATTERN[47 - 8 * sig_idx -: 8];
	wire stat_fail = rd_byte[FLAG_ERASE_FAIL] | rd_byte[FLAG_PROG_FAIL];

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_m <= 1'b0;
			ack_s <= 1'b0;
			rd_m <= 8'h00;
			rd_s <= 8'h00;
		end else begin
			ack_m <= dev_ack;
			ack_s <= ack_m;
			rd_m <= dev_rdata;
			rd_s <= rd_m;
		end
	end

	// ==========================================
	// APB answer, one cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			prdata <= read_word;
			pslverr <= psel & ~penable & ~mapped_addr;
		end
	end

	// ==========================================
	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			ret_state <= ST_IDLE;
			dev_req <= 1'b0;
			dev_op <= OP_READ_BYTE;
			dev_sector <= '0;
			dev_col <= 12'h000;
			dev_wdata <= 8'h00;
			buf_addr <= 12'h000;
			buf_hold <= 1'b0;
			ecc_start <= 1'b0;
			ecc_valid <= 1'b0;
			ecc_byte <= 8'h00;
			rd_byte <= 8'h00;
			cnt <= 12'h000;
			scan_sec <= '0;
			lsect <= '0;
			phys <= '0;
			lo_ptr <= POOL_LO;
			hi_ptr <= POOL_HI;
			bad <= '0;
			remap_v <= '0;
			next_slot <= '0;
			spares_left <= POOL_SIZE;
			op_kind <= 3'h0;
			last_stat <= 8'h00;
			busy <= 1'b0;
			scanned <= 1'b0;
			err <= 1'b0;
			replaced <= 1'b0;
			uncorr <= 1'b0;
		end else begin
			ecc_start <= 1'b0;
			ecc_valid <= 1'b0;
			if (apb_write && sel_sector && !busy) begin
				lsect <= pwdata[SW-1:0];
			end
			case (state)
				ST_IDLE: begin
					if (start) begin
						op_kind <= cmd;
						err <= 1'b0;
						replaced <= 1'b0;
						uncorr <= 1'b0;
						cnt <= 12'h000;
						phys <= mapped;
						busy <= 1'b1;
						if (cmd == CMD_SCAN) begin
							scan_sec <= '0;
							state <= ST_SCAN_RD;
						end else if (!cmd_ok) begin
							err <= 1'b1;
							state <= ST_DONE;
						end else if (cmd == CMD_PROGRAM) begin
							buf_addr <= 12'h000;
							state <= ST_LOAD;
						end else if (cmd == CMD_ERASE) begin
							state <= ST_ERASE;
						end else if (cmd == CMD_READ) begin
							ecc_start <= 1'b1;
							state <= ST_ECC_RD;
						end else begin
							err <= 1'b1;
							state <= ST_DONE;
						end
					end
				end
				ST_SCAN_RD: begin
					dev_op <= OP_READ_BYTE;
					dev_sector <= scan_sec;
					dev_col <= SIG_COL + cnt;
					ret_state <= ST_SCAN_CHK;
					state <= ST_REQ;
				end
				ST_SCAN_CHK: begin
					if (rd_byte != sig_byte || cnt[2:0] == SIG_LAST) begin
						bad[scan_sec] <= (rd_byte != sig_byte);
						cnt <= 12'h000;
						scan_sec <= scan_sec + 1'b1;
						if (scan_sec == POOL_HI) begin
							scanned <= 1'b1;
							state <= ST_DONE;
						end else begin
							state <= ST_SCAN_RD;
						end
					end else begin
						cnt <= cnt + 1'b1;
						state <= ST_SCAN_RD;
					end
				end
				ST_LOAD: begin
					dev_op <= OP_LOAD_BYTE;
					dev_sector <= phys;
					dev_col <= cnt;
					dev_wdata <= buf_data;
					ret_state <= ST_LOAD_NEXT;
					state <= ST_REQ;
				end
				ST_LOAD_NEXT: begin
					if (cnt == LAST_COL) begin
						state <= ST_PROG;
					end else begin
						cnt <= cnt + 1'b1;
						buf_addr <= cnt + 1'b1;
						state <= ST_LOAD;
					end
				end
				ST_PROG: begin
					dev_op <= OP_PROGRAM;
					dev_sector <= phys;
					ret_state <= ST_POLL;
					state <= ST_REQ;
				end
				ST_ERASE: begin
					dev_op <= OP_ERASE;
					dev_sector <= phys;
					ret_state <= ST_POLL;
					state <= ST_REQ;
				end
				ST_POLL: begin
					dev_op <= OP_STATUS;
					ret_state <= ST_CHECK;
					state <= ST_REQ;
				end
				ST_CHECK: begin
					last_stat <= rd_byte;
					if (!rd_byte[FLAG_READY]) begin
						state <= ST_POLL;
					end else if (stat_fail) begin
						err <= 1'b1;
						state <= ST_CLEAR;
					end else begin
						state <= ST_DONE;
					end
				end
				ST_CLEAR: begin
					dev_op <= OP_CLEAR;
					ret_state <= ST_DECIDE;
					state <= ST_REQ;
				end
				ST_DECIDE: begin
					if (last_stat[FLAG_ECC_HINT]) begin
						buf_hold <= 1'b1;
						cnt <= 12'h000;
						ecc_start <= 1'b1;
						state <= ST_ECC_RD;
					end else begin
						state <= ST_REPLACE;
					end
				end
				ST_ECC_RD: begin
					dev_op <= OP_READ_BYTE;
					dev_sector <= phys;
					dev_col <= cnt;
					ret_state <= ST_ECC_FEED;
					state <= ST_REQ;
				end
				ST_ECC_FEED: begin
					ecc_valid <= 1'b1;
					ecc_byte <= rd_byte;
					if (cnt == LAST_COL) begin
						state <= ST_ECC_WAIT;
					end else begin
						cnt <= cnt + 1'b1;
						state <= ST_ECC_RD;
					end
				end
				ST_ECC_WAIT: begin
					if (ecc_done) begin
						uncorr <= ~ecc_fixable;
						if (op_kind == CMD_READ || ecc_fixable) begin
							state <= ST_DONE;
						end else begin
							state <= ST_REPLACE;
						end
					end
				end
				ST_REPLACE: begin
					if (spares_left == '0) begin
						bad[phys] <= 1'b1;
						state <= ST_DONE;
					end else begin
						spares_left <= spares_left - 1'b1;
						if (want_hi) begin
							hi_ptr <= hi_ptr - 1'b1;
						end else begin
							lo_ptr <= lo_ptr + 1'b1;
						end
						// Spares found unusable by the scan are skipped and lost.
						if (!bad[cand]) begin
							bad[phys] <= 1'b1;
							phys <= cand;
							replaced <= 1'b1;
							if (hit) begin
								remap_phy[hit_idx] <= cand;
							end else begin
								remap_log[next_slot] <= lsect;
								remap_phy[next_slot] <= cand;
								remap_v[next_slot] <= 1'b1;
								next_slot <= next_slot + 1'b1;
							end
							cnt <= 12'h000;
							buf_addr <= 12'h000;
							// Erase the spare again for an erase; for a program, reload it from the buffer.
							state <= (op_kind == CMD_ERASE) ? ST_ERASE : ST_LOAD;
						end
					end
				end
				ST_REQ: begin
					dev_req <= 1'b1;
					if (dev_req && ack_s) begin
						rd_byte <= rd_s;
						dev_req <= 1'b0;
						state <= ST_REL;
					end
				end
				ST_REL: begin
					if (!ack_s) begin
						state <= ret_state;
					end
				end
				ST_DONE: begin
					busy <= 1'b0;
					buf_hold <= 1'b0;
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

//--- tb/fbsm_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fbsm_ctrl_asserts import fbsm_pkg::*; #(
	parameter int NS = 64,
	parameter int SPARE_N = 4
) (
	// Clock, reset and APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Device link and ECC
	input wire logic dev_req,
	input wire logic [2:0] dev_op,
	input wire logic [$clog2(NS)-1:0] dev_sector,
	input wire logic [11:0] dev_col,
	input wire logic dev_ack,
	input wire logic ecc_start,
	input wire logic ecc_valid
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// Sequences
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_ack_seen;
		dev_req && $rose(dev_ack);
	endsequence
	// ==========================================
	// Properties
	a_apb_zero_wait: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_unmapped_err: assert property ((s_setup and (!pwrite && paddr > 8'h14))
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	a_caps_three: assert property ((s_setup and (!pwrite && paddr == REG_CAPS))
		|=> prdata == ECC_BITS)
		else $error("ecc capability wrong");
	a_req_waits_ack: assert property (dev_req && !dev_ack |=> dev_req)
		else $error("request dropped before ack");
	a_no_req_ack_high: assert property (!dev_req && dev_ack |=> !dev_req)
		else $error("request while ack high");
	a_fields_stable: assert property (dev_req && $past(dev_req)
		|-> $stable(dev_op) && $stable(dev_sector) && $stable(dev_col))
		else $error("fields moved during request");
	a_req_release: assert property (s_ack_seen |-> ##[1:4] !dev_req)
		else $error("request not released");
	a_ecc_start_pulse: assert property (ecc_start |=> !ecc_start)
		else $error("ecc start too long");
	a_ecc_byte_pulse: assert property (ecc_valid |=> !ecc_valid)
		else $error("ecc byte pulse too long");
endmodule
`default_nettype wire

//--- tb/fbsm_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module fbsm_dev_model import fbsm_pkg::*; #(
	parameter int NS = 64,
	parameter int BAD = 5
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Device link
	input wire logic dev_req,
	input wire logic [2:0] dev_op,
	input wire logic [$clog2(NS)-1:0] dev_sector,
	input wire logic [11:0] dev_col,
	input wire logic [7:0] dev_wdata,
	output logic dev_ack,
	output logic [7:0] dev_rdata,
	// Buffer and ECC engine
	input wire logic [11:0] buf_addr,
	output logic [7:0] buf_data,
	input wire logic buf_hold,
	input wire logic ecc_start,
	input wire logic ecc_valid,
	input wire logic [7:0] ecc_byte,
	output logic ecc_done,
	output logic ecc_fixable
);
	// Every illegal access by the controller bumps viol.
	int fail_sec = -1, lat = 0, wt = 0, viol = 0, nops = 0, loads = 0, ecnt = 0;
	bit hint, fix, pend, need_st, bsy, hold_seen;
	bit dead [NS];
	logic [7:0] stat = 8'h80;
	logic [7:0] rd_last = 8'h00;
	// The buffer answers within the cycle in which its address changes.
	assign buf_data = buf_addr[7:0] ^ 8'h5A;
	initial begin
		dev_rdata = 8'h00;
		ecc_done = 1'b0;
		ecc_fixable = 1'b0;
	end
	task automatic do_op();
		int s;
		int k;
		s = dev_sector;
		k = dev_col - SIG_COL;
		nops++;
		if (dead[s] && dev_op < OP_STATUS && !(hint && dev_op == OP_READ_BYTE)) viol++;
		case (dev_op)
			OP_READ_BYTE: begin
				rd_last = (s != BAD && k >= 0 && k <= 5) ? SIG_PATTERN[47 - 8 * k -: 8] : 8'hFF;
				dev_rdata <= rd_last;
			end
			OP_LOAD_BYTE: begin
				loads++;
				if (dev_wdata !== (dev_col[7:0] ^ 8'h5A)) viol++;
			end
			OP_PROGRAM, OP_ERASE: begin
				if (s == BAD || pend || need_st) viol++;
				if (dev_op == OP_PROGRAM && loads != 2112) viol++;
				loads = 0;
				need_st = 1;
				bsy = 1;
				if (s == fail_sec) begin
					pend = 1;
					dead[s] = 1;
					stat = {1'b1, hint, dev_op == OP_ERASE, dev_op == OP_PROGRAM, 4'h0};
					fail_sec = -1;
				end
			end
			OP_STATUS: begin
				dev_rdata <= bsy ? 8'h00 : stat;
				need_st = bsy;
				bsy = 0;
			end
			OP_CLEAR: begin
				pend = 0;
				stat = 8'h80;
			end
			default: viol++;
		endcase
	endtask
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_ack <= 1'b0;
		end else if (dev_req && !dev_ack) begin
			if (wt < lat) begin
				wt++;
			end else begin
				wt = 0;
				do_op();
				dev_ack <= 1'b1;
			end
		end else if (!dev_req && dev_ack) begin
			dev_ack <= 1'b0;
			dev_rdata <= ~dev_rdata;
		end
	end
	always @(posedge pclk) begin
		hold_seen |= buf_hold;
		ecc_done <= 1'b0;
		if (ecc_start) begin
			ecnt = 0;
		end else if (ecc_valid) begin
			ecnt++;
			if (ecc_byte !== rd_last) viol++;
			if (ecnt == 2112) begin
				ecc_done <= 1'b1;
				ecc_fixable <= fix;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import fbsm_pkg::*; ;
	localparam int NSX = 64;
	localparam int SPX = 4;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic qe;
	logic pready, pslverr, dev_req, dev_ack, buf_hold, ecc_start, ecc_valid, ecc_done, ecc_fixable;
	logic [2:0] dev_op;
	logic [5:0] dev_sector;
	logic [11:0] dev_col, buf_addr;
	logic [7:0] dev_wdata, dev_rdata, buf_data, ecc_byte;
	int err_count = 0, comparisons = 0, n0;
	fbsm_ctrl #(.NS(NSX), .SPARE_N(SPX)) dut (.*);
	fbsm_dev_model #(.NS(NSX)) dev (.*);
	always #5 pclk = ~pclk;
	// ==========================================
	// Access tasks
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		qe = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, q & m);
	endtask
	task automatic cmd(input int s, input logic [2:0] c);
		apb(1'b1, REG_SECTOR, s);
		apb(1'b1, REG_CTRL, {29'h0, c});
		do begin
			repeat (20) @(posedge pclk);
			apb(1'b0, REG_STATUS, 32'h0);
		end while (q[0] !== 1'b0);
	endtask
	task automatic close_out();
		if (err_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================
	// Tests
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc("spares", REG_SPARES, '1, SPX);
		rc("caps", REG_CAPS, '1, ECC_BITS);
		chk("caps slverr", 0, qe);
		rc("unmapped", 8'h18, '1, 32'h0);
		chk("unmapped slverr", 1, qe);
		cmd(1, CMD_ERASE);
		rc("unscanned", REG_STATUS, 32'h4, 32'h4);
		chk("ops before scan", 0, dev.nops);
		dev.lat = 3;
		cmd(0, CMD_SCAN);
		rc("scanned", REG_STATUS, 32'h6, 32'h2);
		dev.lat = 0;
		n0 = dev.nops;
		cmd(5, CMD_PROGRAM);
		rc("bad sector", REG_STATUS, 32'h4, 32'h4);
		cmd(NSX - SPX, CMD_READ);
		rc("spare refused", REG_STATUS, 32'h4, 32'h4);
		chk("refused ops", n0, dev.nops);
		dev.fail_sec = 2;
		dev.hint = 1'b0;
		cmd(2, CMD_PROGRAM);
		rc("replaced", REG_STATUS, 32'h8, 32'h8);
		rc("phys", REG_PHYS, '1, NSX - 1);
		rc("spares left", REG_SPARES, '1, SPX - 1);
		chk("no hold", 0, dev.hold_seen);
		dev.fail_sec = 3;
		dev.hint = 1'b1;
		dev.fix = 1'b1;
		cmd(3, CMD_ERASE);
		rc("kept", REG_STATUS, 32'h18, 32'h0);
		rc("phys kept", REG_PHYS, '1, 3);
		chk("hold", 1, dev.hold_seen);
		chk("device misuse", 0, dev.viol);
		close_out();
	end
	initial begin
		#(100000 * 10);
		err_count++;
		close_out();
	end
endmodule
bind fbsm_ctrl fbsm_ctrl_asserts #(.NS(NS), .SPARE_N(SPARE_N)) u_chk (.*);
`default_nettype wire
